// >>> design/ulms_pkg.sv
// Purpose: Constants and carriers for the line and modem status block.
// Assumes: Byte-wide register window, one clock at 200 MHz.
// Notes: Receive data line and modem inputs are synchronous to clock.
package ulms_pkg;
    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [2:0] ULMS_OFS_LINE_STATUS = 3'h5;
    localparam logic [2:0] ULMS_OFS_MODEM_STATUS = 3'h6;
    localparam logic [7:0] ULMS_LINE_STATUS_RST = 8'h60;
    localparam logic [7:0] ULMS_MODEM_STATUS_RST = 8'h00;
    // Line status field positions
    localparam int ULMS_LS_DR = 0;
    localparam int ULMS_LS_OE = 1;
    localparam int ULMS_LS_PE = 2;
    localparam int ULMS_LS_FE = 3;
    localparam int ULMS_LS_BI = 4;
    localparam int ULMS_LS_THRE = 5;
    localparam int ULMS_LS_TEMT = 6;
    localparam int ULMS_LS_FERR = 7;
    // Modem status field positions
    localparam int ULMS_MS_DCTS = 0;
    localparam int ULMS_MS_DDSR = 1;
    localparam int ULMS_MS_TERI = 2;
    localparam int ULMS_MS_DDCD = 3;
    localparam int ULMS_MS_CTS = 4;
    localparam int ULMS_MS_DSR = 5;
    localparam int ULMS_MS_RI = 6;
    localparam int ULMS_MS_DCD = 7;
    // ------------------------------------------------------------
    // Receive sizing
    // ------------------------------------------------------------
    localparam int ULMS_FIFO_DEPTH = 16;
    localparam int ULMS_PTR_W = 4;
    localparam int ULMS_OVS = 16;
    localparam logic [3:0] ULMS_OVS_MID = 4'h7;
    localparam logic [3:0] ULMS_OVS_LAST = 4'hF;
    localparam logic [1:0] ULMS_PAR_ODD = 2'h0;
    localparam logic [1:0] ULMS_PAR_EVEN = 2'h1;
    localparam logic [1:0] ULMS_PAR_SPACE = 2'h2;
    localparam logic [1:0] ULMS_PAR_MARK = 2'h3;

    // Line format as held by the line control logic outside
    typedef struct packed {
        logic [1:0] word_len;   // 0..3 = 5..8 data bits
        logic two_stop;
        logic par_en;
        logic [1:0] par_mode;
    } ulms_fmt_t;

    // Modem input lines, 1 = active
    typedef struct packed {
        logic dcd;
        logic ri;
        logic dsr;
        logic cts;
    } ulms_modem_t;

    // One received character with its error marks
    typedef struct packed {
        logic [7:0] data;
        logic brk;
        logic fe;
        logic pe;
    } ulms_rx_char_t;
endpackage

// >>> design/ulms_rx_frame.sv
// Purpose: Serial receive framer feeding the status logic.
// Assumes: rxd synchronous to clock, bit_tick at 16x baud.
// Notes: Reports one pulse per character or break condition.
`timescale 1ns/1ps
module ulms_rx_frame (
    input wire logic clock,                      // System clock
    input wire logic arst_n,                     // Async reset, low
    input wire logic clk_en,                     // Freeze when low
    input wire logic bit_tick,                   // 16x baud strobe
    input wire logic rxd,                        // Receive data line
    input wire ulms_pkg::ulms_fmt_t fmt,         // Line format
    output ulms_pkg::ulms_rx_char_t char_o,      // Received character
    output logic char_vld,                       // Character pulse
    output logic brk_det                         // Break pulse
);
    import ulms_pkg::*;

    typedef enum logic [1:0] {ULMS_IDLE, ULMS_START, ULMS_BITS, ULMS_STOP} ulms_rx_st_t;

    ulms_rx_st_t st_r;
    logic [3:0] ovs_r;
    logic [3:0] nbit_r;
    logic [8:0] shf_r;
    logic [7:0] data_w;
    logic [3:0] nbits_w;
    logic par_bit_w;
    logic par_exp_w;
    logic all_zero_r;
    logic brk_hold_r;
    logic [3:0] shift_w;
    logic [7:0] mask_w;

    assign nbits_w = {2'h0, fmt.word_len} + 4'h5 + {3'h0, fmt.par_en};
    // Frame enters at bit 8; realign so data sits at bit 0, parity masked off
    assign shift_w = 4'h9 - nbits_w;
    assign mask_w = 8'hFF >> (3'h3 - {1'b0, fmt.word_len});
    assign data_w = 8'(shf_r >> shift_w) & mask_w;
    assign par_bit_w = shf_r[8];
    always_comb begin
        unique case (fmt.par_mode)
            ULMS_PAR_ODD: par_exp_w = ~(^data_w);
            ULMS_PAR_EVEN: par_exp_w = ^data_w;
            ULMS_PAR_SPACE: par_exp_w = 1'b0;
            ULMS_PAR_MARK: par_exp_w = 1'b1;
        endcase
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            st_r <= ULMS_IDLE;
            ovs_r <= 4'h0;
            nbit_r <= 4'h0;
            shf_r <= 9'h000;
            all_zero_r <= 1'b0;
            brk_hold_r <= 1'b0;
            char_o <= '0;
            char_vld <= 1'b0;
            brk_det <= 1'b0;
        end else if (clk_en) begin
            char_vld <= 1'b0;
            brk_det <= 1'b0;
            if (bit_tick) begin
                unique case (st_r)
                    ULMS_IDLE: begin
                        ovs_r <= 4'h0;
                        // A held break must return to mark before rearming
                        if (rxd) begin
                            brk_hold_r <= 1'b0;
                        end else if (!brk_hold_r) begin
                            st_r <= ULMS_START;
                        end
                    end
                    ULMS_START: begin
                        ovs_r <= ovs_r + 4'h1;
                        if (ovs_r == ULMS_OVS_MID) begin
                            ovs_r <= 4'h0;
                            nbit_r <= 4'h0;
                            all_zero_r <= 1'b1;
                            st_r <= rxd ? ULMS_IDLE : ULMS_BITS;
                        end
                    end
                    ULMS_BITS: begin
                        ovs_r <= ovs_r + 4'h1;
                        if (ovs_r == ULMS_OVS_LAST) begin
                            shf_r <= {rxd, shf_r[8:1]};
                            all_zero_r <= all_zero_r & ~rxd;
                            nbit_r <= nbit_r + 4'h1;
                            if (nbit_r == nbits_w - 4'h1) begin
                                st_r <= ULMS_STOP;
                            end
                        end
                    end
                    ULMS_STOP: begin
                        ovs_r <= ovs_r + 4'h1;
                        // Second stop bit never sampled
                        if (ovs_r == ULMS_OVS_LAST) begin
                            char_vld <= 1'b1;
                            char_o.fe <= ~rxd;
                            char_o.pe <= fmt.par_en & (par_bit_w != par_exp_w);
                            // Whole frame low: start, data, parity, stop
                            char_o.brk <= all_zero_r & ~rxd;
                            brk_det <= all_zero_r & ~rxd;
                            brk_hold_r <= all_zero_r & ~rxd;
                            char_o.data <= data_w;
                            st_r <= ULMS_IDLE;
                        end
                    end
                endcase
            end
        end
    end
endmodule

// >>> design/ulms_status.sv
// Purpose: Line status and modem status registers of the serial port.
// Assumes: Register reads arrive as a one-cycle strobe with offset.
// Notes: Transmit side only reports its empty levels to this block.
`timescale 1ns/1ps
module ulms_status (
    input wire logic clock,                      // System clock
    input wire logic arst_n,                     // Async reset, low
    input wire logic clk_en,                     // Freeze when low
    input wire logic bit_tick,                   // 16x baud strobe
    input wire logic rxd,                        // Receive data line
    input wire ulms_pkg::ulms_fmt_t fmt,         // Line format
    input wire ulms_pkg::ulms_modem_t modem_in,  // Modem lines, 1 active
    input wire logic thr_empty,                  // Holding reg empty
    input wire logic tsr_empty,                  // Shift reg empty
    input wire logic rbr_rd,                     // Receive buffer read
    input wire logic reg_rd,                     // Register read strobe
    input wire logic [2:0] reg_addr,             // Register offset
    output logic [7:0] reg_rdata,                // Read data
    output logic [7:0] line_status,              // Line status view
    output logic [7:0] modem_line_status,        // Modem status view
    output logic [7:0] rx_data,                  // Head of receive FIFO
    output logic rx_data_vld                     // Head valid
);
    import ulms_pkg::*;

    // ------------------------------------------------------------
    // Receive framer and FIFO
    // ------------------------------------------------------------
    ulms_rx_char_t rx_char;
    logic rx_vld;
    logic brk_pulse;

    ulms_rx_frame u_frame (
        .clock(clock),
        .arst_n(arst_n),
        .clk_en(clk_en),
        .bit_tick(bit_tick),
        .rxd(rxd),
        .fmt(fmt),
        .char_o(rx_char),
        .char_vld(rx_vld),
        .brk_det(brk_pulse)
    );

    ulms_rx_char_t mem_r [ULMS_FIFO_DEPTH];
    logic [ULMS_PTR_W:0] wp_r;
    logic [ULMS_PTR_W:0] rp_r;
    logic [ULMS_PTR_W:0] cnt_w;
    logic full_w;
    logic empty_w;
    logic push_w;
    logic pop_w;
    logic [ULMS_FIFO_DEPTH-1:0] err_tag_r;
    logic [ULMS_FIFO_DEPTH-1:0] live_w;

    assign cnt_w = wp_r - rp_r;
    assign empty_w = (cnt_w == '0);
    assign full_w = cnt_w[ULMS_PTR_W];
    // Full FIFO drops the new character; the held ones are kept
    assign push_w = rx_vld & ~full_w;
    assign pop_w = rbr_rd & ~empty_w;

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            wp_r <= '0;
            rp_r <= '0;
        end else if (clk_en) begin
            if (push_w) begin
                wp_r <= wp_r + 1'b1;
            end
            if (pop_w) begin
                rp_r <= rp_r + 1'b1;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (clk_en && push_w) begin
            mem_r[wp_r[ULMS_PTR_W-1:0]] <= rx_char;
        end
    end

    // Per-entry error marks and occupancy
    genvar gi;
    generate
        for (gi = 0; gi < ULMS_FIFO_DEPTH; gi++) begin : g_ent
            logic [ULMS_PTR_W-1:0] ofs_w;
            assign ofs_w = ULMS_PTR_W'(gi) - rp_r[ULMS_PTR_W-1:0];
            assign live_w[gi] = ({1'b0, ofs_w} < cnt_w);
            always_ff @(posedge clock or negedge arst_n) begin
                if (!arst_n) begin
                    err_tag_r[gi] <= 1'b0;
                end else if (clk_en && push_w && wp_r[ULMS_PTR_W-1:0] == ULMS_PTR_W'(gi)) begin
                    err_tag_r[gi] <= rx_char.brk | rx_char.fe | rx_char.pe;
                end
            end
        end
    endgenerate

    logic fifo_err_w;
    assign fifo_err_w = |(err_tag_r & live_w);

    // ------------------------------------------------------------
    // Line status flags
    // ------------------------------------------------------------
    logic ls_rd_w;
    logic ms_rd_w;
    logic oe_r;
    logic pe_r;
    logic fe_r;
    logic bi_r;
    logic ferr_r;

    assign ls_rd_w = reg_rd & (reg_addr == ULMS_OFS_LINE_STATUS);
    assign ms_rd_w = reg_rd & (reg_addr == ULMS_OFS_MODEM_STATUS);

    // Set wins over the read-clear in the same cycle
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            oe_r <= 1'b0;
            pe_r <= 1'b0;
            fe_r <= 1'b0;
            bi_r <= 1'b0;
        end else if (clk_en) begin
            oe_r <= (rx_vld & full_w) | (oe_r & ~ls_rd_w);
            pe_r <= (push_w & rx_char.pe) | (pe_r & ~ls_rd_w);
            fe_r <= (push_w & rx_char.fe) | (fe_r & ~ls_rd_w);
            bi_r <= brk_pulse | (bi_r & ~ls_rd_w);
        end
    end

    // Sets on any errored byte; drops only after a read with none left
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            ferr_r <= 1'b0;
        end else if (clk_en) begin
            if (push_w && (rx_char.brk || rx_char.fe || rx_char.pe)) begin
                ferr_r <= 1'b1;
            end else if (ls_rd_w && !fifo_err_w) begin
                ferr_r <= 1'b0;
            end else if (fifo_err_w) begin
                ferr_r <= 1'b1;
            end
        end
    end

    logic [7:0] ls_w;
    always_comb begin
        ls_w = '0;
        ls_w[ULMS_LS_DR] = ~empty_w;
        ls_w[ULMS_LS_OE] = oe_r;
        ls_w[ULMS_LS_PE] = pe_r;
        ls_w[ULMS_LS_FE] = fe_r;
        ls_w[ULMS_LS_BI] = bi_r;
        ls_w[ULMS_LS_THRE] = thr_empty;
        ls_w[ULMS_LS_TEMT] = thr_empty & tsr_empty;
        ls_w[ULMS_LS_FERR] = ferr_r;
    end

    // ------------------------------------------------------------
    // Modem status
    // ------------------------------------------------------------
    ulms_modem_t mdm_r;
    logic dcts_r;
    logic ddsr_r;
    logic teri_r;
    logic ddcd_r;

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            mdm_r <= '0;
        end else if (clk_en) begin
            mdm_r <= modem_in;
        end
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            dcts_r <= 1'b0;
            ddsr_r <= 1'b0;
            teri_r <= 1'b0;
            ddcd_r <= 1'b0;
        end else if (clk_en) begin
            dcts_r <= (modem_in.cts ^ mdm_r.cts) | (dcts_r & ~ms_rd_w);
            ddsr_r <= (modem_in.dsr ^ mdm_r.dsr) | (ddsr_r & ~ms_rd_w);
            ddcd_r <= (modem_in.dcd ^ mdm_r.dcd) | (ddcd_r & ~ms_rd_w);
            // Ring flag also clears on read, as the customary port does
            teri_r <= (modem_in.ri & ~mdm_r.ri) | (teri_r & ~ms_rd_w);
        end
    end

    logic [7:0] ms_w;
    always_comb begin
        ms_w = '0;
        ms_w[ULMS_MS_DCTS] = dcts_r;
        ms_w[ULMS_MS_DDSR] = ddsr_r;
        ms_w[ULMS_MS_TERI] = teri_r;
        ms_w[ULMS_MS_DDCD] = ddcd_r;
        ms_w[ULMS_MS_CTS] = mdm_r.cts;
        ms_w[ULMS_MS_DSR] = mdm_r.dsr;
        ms_w[ULMS_MS_RI] = mdm_r.ri;
        ms_w[ULMS_MS_DCD] = mdm_r.dcd;
    end

    // ------------------------------------------------------------
    // Registered outputs
    // ------------------------------------------------------------
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            line_status <= ULMS_LINE_STATUS_RST;
            modem_line_status <= ULMS_MODEM_STATUS_RST;
            reg_rdata <= 8'h00;
            rx_data <= 8'h00;
            rx_data_vld <= 1'b0;
        end else if (clk_en) begin
            line_status <= ls_w;
            modem_line_status <= ms_w;
            rx_data <= mem_r[rp_r[ULMS_PTR_W-1:0]].data;
            rx_data_vld <= ~empty_w;
            if (reg_rd) begin
                unique case (reg_addr)
                    ULMS_OFS_LINE_STATUS: reg_rdata <= ls_w;
                    ULMS_OFS_MODEM_STATUS: reg_rdata <= ms_w;
                    default: reg_rdata <= 8'h00;
                endcase
            end
        end
    end
endmodule

// >>> test/ulms_props.sv
// Purpose: Port-level checks for the line and modem status block.
// Assumes: One clock, reset async and active low.
// Notes: Bound to ulms_status at the foot of this file.
`timescale 1ns/1ps
module ulms_props (
    input wire logic clock, // Clock
    input wire logic arst_n, // Reset, low
    input wire logic clk_en, // Run enable
    input wire ulms_pkg::ulms_modem_t modem_in, // Modem lines
    input wire logic thr_empty, // Holding empty
    input wire logic tsr_empty, // Shift empty
    input wire logic reg_rd, // Read strobe
    input wire logic [2:0] reg_addr, // Offset
    input wire logic [7:0] reg_rdata, // Read data
    input wire logic [7:0] line_status, // Line view
    input wire logic [7:0] modem_line_status, // Modem view
    input wire logic rx_data_vld // Head valid
);
    import ulms_pkg::*;
    logic [1:0] up_r;
    // ------------------------------
    // Edges since reset release
    // ------------------------------
    // Keeps $past from looking back into reset
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            up_r <= 2'h0;
        end else if (up_r != 2'h3) begin
            up_r <= up_r + 2'h1;
        end
    end
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!arst_n);
    sequence quiet_s;
        $stable(modem_in) && clk_en;
    endsequence
    sequence rd_modem_s;
        reg_rd && reg_addr == ULMS_OFS_MODEM_STATUS;
    endsequence
    // ------------------------------
    // Properties
    // ------------------------------
    thre_view_a: assert property (
        up_r != 2'h0 && $past(clk_en) |-> line_status[ULMS_LS_THRE] == $past(thr_empty))
        else $error("holding empty bit wrong");
    temt_view_a: assert property (
        up_r != 2'h0 && $past(clk_en)
        |-> line_status[ULMS_LS_TEMT] == $past(thr_empty && tsr_empty))
        else $error("both empty bit wrong");
    ready_follow_a: assert property (
        up_r != 2'h0 |-> line_status[ULMS_LS_DR] == rx_data_vld)
        else $error("data ready disagrees with head valid");
    fifo_err_a: assert property (
        up_r != 2'h0 && $rose(line_status[ULMS_LS_FERR]) |-> rx_data_vld || $past(rx_data_vld))
        else $error("fifo error bit set with empty fifo");
    modem_level_a: assert property (
        up_r[1] && $past(clk_en) && $past(clk_en, 2)
        |-> modem_line_status[7:4] == $past(modem_in, 2))
        else $error("modem levels wrong");
    ring_rise_a: assert property (
        up_r != 2'h0 && $rose(modem_in.ri) && clk_en |-> ##[1:3] modem_line_status[ULMS_MS_TERI])
        else $error("ring edge flag missing");
    delta_clear_a: assert property (
        up_r == 2'h3 ##0 quiet_s[*4] ##0 rd_modem_s ##1 quiet_s[*2]
        |-> modem_line_status[3:0] == 4'h0)
        else $error("modem change flags not cleared by read");
    bad_offset_a: assert property (
        reg_rd && clk_en && reg_addr != 3'h5 && reg_addr != 3'h6 |=> reg_rdata == 8'h00)
        else $error("unmapped offset read not zero");
    rdata_hold_a: assert property (
        up_r != 2'h0 && !(reg_rd && clk_en) |=> $stable(reg_rdata))
        else $error("read data moved without a read");
endmodule
bind ulms_status ulms_props u_ulms_props (
    .clock(clock), .arst_n(arst_n), .clk_en(clk_en), .modem_in(modem_in),
    .thr_empty(thr_empty), .tsr_empty(tsr_empty), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_rdata(reg_rdata), .line_status(line_status), .modem_line_status(modem_line_status),
    .rx_data_vld(rx_data_vld));

// >>> test/ulms_remote.sv
// Purpose: Remote serial device on the receive and modem lines.
// Assumes: bit_tick is the 16x oversample strobe of the block.
// Notes: Frames go out LSB first; line idles high between frames.
`timescale 1ns/1ps
module ulms_remote (
    input wire logic clock, // Clock
    input wire logic bit_tick, // 16x strobe
    output logic rxd, // Serial data
    output ulms_pkg::ulms_modem_t modem_in // Modem lines
);
    import ulms_pkg::*;
    initial begin
        rxd = 1'b1;
        modem_in = '0;
    end
    // ------------------------------
    // Line drivers
    // ------------------------------
    task automatic ticks(input int n);
        repeat (n) begin
            @(posedge clock);
            while (bit_tick !== 1'b1) @(posedge clock);
        end
    endtask
    // Random gap lets the far end answer both promptly and slowly
    task automatic send(input logic [12:0] v, input int n, input int gap);
        for (int i = 0; i < n; i++) begin
            rxd <= v[i];
            ticks(16);
        end
        rxd <= 1'b1;
        ticks(gap);
    endtask
    task automatic set_modem(input ulms_modem_t m);
        @(posedge clock);
        modem_in <= m;
    endtask
endmodule

// >>> test/testbench.sv
// Purpose: Self-checking bench for the line and modem status block.
// Assumes: 8 data bits, bit_tick every second clock.
// Notes: Frames come from the frame function; modem change expectations from mdelta.
`timescale 1ns/1ps
module testbench;
    import ulms_pkg::*;
    logic clock, arst_n, clk_en, bit_tick, thr_empty, tsr_empty, rbr_rd, reg_rd, rxd;
    logic rx_data_vld;
    logic [2:0] reg_addr;
    logic [7:0] reg_rdata, line_status, modem_line_status, rx_data, rd, d;
    ulms_fmt_t fmt;
    ulms_modem_t modem_in, prev;
    int err_total = 0;
    int samples_checked = 0;
    ulms_status u_ulms_status (.clock(clock), .arst_n(arst_n), .clk_en(clk_en),
        .bit_tick(bit_tick), .rxd(rxd), .fmt(fmt), .modem_in(modem_in),
        .thr_empty(thr_empty), .tsr_empty(tsr_empty), .rbr_rd(rbr_rd), .reg_rd(reg_rd),
        .reg_addr(reg_addr), .reg_rdata(reg_rdata), .line_status(line_status),
        .modem_line_status(modem_line_status), .rx_data(rx_data), .rx_data_vld(rx_data_vld));
    ulms_remote u_ulms_remote (.clock(clock), .bit_tick(bit_tick), .rxd(rxd),
        .modem_in(modem_in));
    initial begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end
    always @(posedge clock) bit_tick <= ~bit_tick;
    // ------------------------------
    // Helpers
    // ------------------------------
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_total++;
            $display("ERROR at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clock);
    endtask
    task automatic rd_reg(input logic [2:0] a);
        reg_rd <= 1'b1;
        reg_addr <= a;
        cyc(1);
        reg_rd <= 1'b0;
        cyc(2);
        rd = reg_rdata;
    endtask
    task automatic pop;
        rbr_rd <= 1'b1;
        cyc(1);
        rbr_rd <= 1'b0;
        cyc(2);
    endtask
    task automatic xmit(input logic [12:0] v, input int n);
        u_ulms_remote.send(v, n, $urandom_range(0, 8));
        cyc(6);
    endtask
    function automatic logic pbit(input logic [7:0] v, input logic [1:0] m);
        case (m)
            ULMS_PAR_ODD: return ~^v;
            ULMS_PAR_EVEN: return ^v;
            ULMS_PAR_SPACE: return 1'b0;
            default: return 1'b1;
        endcase
    endfunction
    // Start bit first; bit 12 keeps the line high
    function automatic logic [12:0] frame(input logic [7:0] v, input logic pe,
            input logic s1, input logic s2);
        return {1'b1, s2, s1, pbit(v, fmt.par_mode) ^ pe, v, 1'b0};
    endfunction
    function automatic logic [3:0] mdelta(input logic [3:0] p, input logic [3:0] n);
        return {p[3] ^ n[3], n[2] & ~p[2], p[1] ^ n[1], p[0] ^ n[0]};
    endfunction
    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    initial begin
        cyc(40000);
        err_total++;
        tally_and_finish;
    end
    // ------------------------------
    // Main sequence
    // ------------------------------
    initial begin
        int m;
        logic f;
        m = $urandom(17);
        {arst_n, bit_tick, rbr_rd, reg_rd, reg_addr} = '0;
        {clk_en, thr_empty, tsr_empty} = 3'h7;
        fmt = 6'h35; // 8 data bits, even parity
        cyc(12);
        chk(line_status, 8'h60);
        chk(modem_line_status, 8'h00);
        arst_n <= 1'b1;
        cyc(2);
        rd_reg(ULMS_OFS_LINE_STATUS);
        chk(rd, ULMS_LINE_STATUS_RST);
        rd_reg(ULMS_OFS_MODEM_STATUS);
        chk(rd, ULMS_MODEM_STATUS_RST);
        for (int a = 0; a < 8; a++) begin
            if (a != 5 && a != 6) begin
                rd_reg(3'(a));
                chk(rd, 8'h00);
            end
        end
        for (int i = 0; i < 9; i++) begin
            thr_empty <= 1'($urandom_range(0, 1));
            tsr_empty <= 1'($urandom_range(0, 1));
            cyc(3);
            chk({6'h0, line_status[6:5]}, {6'h0, thr_empty & tsr_empty, thr_empty});
        end
        clk_en <= 1'b0;
        thr_empty <= ~thr_empty;
        cyc(3);
        chk({7'h0, line_status[5]}, {7'h0, ~thr_empty});
        {clk_en, thr_empty, tsr_empty} <= 3'h7;
        cyc(3);
        for (int i = 0; i < 8; i++) begin
            f = i[2];
            fmt.par_mode <= 2'(i);
            d = 8'($urandom);
            cyc(2);
            xmit(frame(d, f, 1'b1, 1'b1), 11);
            rd_reg(ULMS_OFS_LINE_STATUS);
            chk(rd, {f, 4'hC, f, 2'h1});
            chk(rx_data, d);
            cyc(1);
            chk(line_status, {f, 7'h61});
            pop;
            rd_reg(ULMS_OFS_LINE_STATUS);
            cyc(1);
            chk(line_status, 8'h60);
        end
        for (int j = 0; j < 2; j++) begin
            fmt.two_stop <= j[0];
            cyc(2);
            xmit(frame(8'($urandom) | 8'h01, 1'b0, 1'b0, 1'b1), 11 + j);
            rd_reg(ULMS_OFS_LINE_STATUS);
            chk(rd, 8'hE9);
            pop;
            rd_reg(ULMS_OFS_LINE_STATUS);
        end
        fmt.two_stop <= 1'b0;
        xmit(13'h0, 13);
        rd_reg(ULMS_OFS_LINE_STATUS);
        chk(rd & 8'h91, 8'h91);
        chk(rx_data, 8'h00);
        pop;
        rd_reg(ULMS_OFS_LINE_STATUS);
        for (int k = 0; k < 17; k++) begin
            xmit(frame(8'(k), 1'b0, 1'b1, 1'b1), 11);
        end
        rd_reg(ULMS_OFS_LINE_STATUS);
        chk(rd & 8'h03, 8'h03);
        for (int k = 0; k < 16; k++) begin
            chk(rx_data, 8'(k));
            pop;
        end
        chk({7'h0, rx_data_vld}, 8'h00);
        prev = '0;
        for (int i = 0; i < 24; i++) begin
            m = $urandom;
            u_ulms_remote.set_modem(ulms_modem_t'(m[3:0]));
            cyc(6);
            rd_reg(ULMS_OFS_MODEM_STATUS);
            chk(rd, {m[3:0], mdelta(prev, m[3:0])});
            cyc(1);
            chk({4'h0, modem_line_status[3:0]}, 8'h00);
            prev = ulms_modem_t'(m[3:0]);
        end
        tally_and_finish;
    end
endmodule
